// ---- host_axi_model.sv ----
module host_axi_model (
   // Clock
   input wire CLK_SYS,
   // Write channels
   output logic [31:0] awaddr,
   output logic awvalid,
   input wire awready,
   output logic [31:0] wdata,
   output logic [3:0] wstrb,
   output logic wvalid,
   input wire wready,
   input wire [1:0] bresp,
   input wire bvalid,
   output logic bready,
   // Read channels
   output logic [31:0] araddr,
   output logic arvalid,
   input wire arready,
   input wire [31:0] rdata,
   input wire [1:0] rresp,
   input wire rvalid,
   output logic rready
);
   timeunit 1ns;
   timeprecision 1ps;
   // Idle bus at time zero
   initial
   begin
      {awaddr, awvalid, wdata, wstrb, wvalid, bready} = 0;
      {araddr, arvalid, rready} = 0;
   end
   // Write: both channels offered at once; released payload is inverted, not kept
   task wr(input [7:0] idx, input [31:0] d, input [3:0] s, output [1:0] r);
      logic aw_done;
      logic w_done;
      aw_done = 0;
      w_done = 0;
      @(posedge CLK_SYS);
      awaddr <= {22'h000000, idx, 2'b00};
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      while (!(aw_done && w_done))
      begin
         @(posedge CLK_SYS);
         if (awvalid && awready)
         begin
            aw_done = 1;
            awvalid <= 1'b0;
            awaddr <= ~awaddr;
         end
         if (wvalid && wready)
         begin
            w_done = 1;
            wvalid <= 1'b0;
            wdata <= ~wdata;
         end
      end
      bready <= 1'b1;
      @(posedge CLK_SYS);
      while (bvalid !== 1'b1) @(posedge CLK_SYS);
      r = bresp;
      bready <= 1'b0;
   endtask
   // Read: hold the address until taken, then wait for the answer
   task rd(input [7:0] idx, output [31:0] d, output [1:0] r);
      @(posedge CLK_SYS);
      araddr <= {22'h000000, idx, 2'b00};
      arvalid <= 1'b1;
      @(posedge CLK_SYS);
      while (arready !== 1'b1) @(posedge CLK_SYS);
      arvalid <= 1'b0;
      araddr <= ~araddr;
      rready <= 1'b1;
      @(posedge CLK_SYS);
      while (rvalid !== 1'b1) @(posedge CLK_SYS);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask
endmodule

// ---- meter_regs_defs.vh ----
`ifndef METER_REGS_DEFS_VH
`define METER_REGS_DEFS_VH
// Register indices (byte address is four times the index)
`define IDX_EVENT_FLAGS 8'h0F
`define IDX_EVENT_ENABLE_MASK 8'h1A
`define IDX_TEMPERATURE_RESULT 8'h1B
`define IDX_CHIP_CONTROL 8'h1C
`define IDX_ACTIVE_PULSE_SOURCE 8'h1D
`define IDX_APPARENT_PULSE_SOURCE 8'h1E
`define IDX_REACTIVE_PULSE_SOURCE 8'h1F
`define IDX_MODE_CONTROL 8'h10
// Reset values
`define RST_EVENT_FLAGS 24'h000001
`define RST_EVENT_ENABLE_MASK 24'h000000
`define RST_CHIP_CONTROL 24'h000000
`define RST_MODE_CONTROL 24'h000000
// Status bit positions
`define BIT_LOW_RATE_READY 23
`define BIT_CUR2_OVER_RANGE 22
`define BIT_VOLT2_OVER_RANGE 21
`define BIT_SAMPLE_READY 20
`define BIT_CUR2_RMS_OVER_RANGE 19
`define BIT_VOLT2_RMS_OVER_RANGE 18
`define BIT_CUR1_OVER_RANGE 17
`define BIT_VOLT1_OVER_RANGE 16
`define BIT_ENERGY2_OVER_RANGE 15
`define BIT_CUR1_RMS_OVER_RANGE 14
`define BIT_VOLT1_RMS_OVER_RANGE 13
`define BIT_ENERGY1_OVER_RANGE 12
`define BIT_CUR1_FAULT_FLAG 11
`define BIT_VOLT1_DIP_FLAG 10
`define BIT_CUR2_FAULT_FLAG 9
`define BIT_VOLT2_DIP_FLAG 8
`define BIT_TEMP_REFRESHED 7
`define BIT_TEMP_MOD_OSC 6
`define BIT_CUR2_MOD_OSC 5
`define BIT_VOLT_MOD_OSC 4
`define BIT_CUR1_MOD_OSC 3
`define BIT_LOW_SUPPLY_FLAG 2
`define BIT_FREQ_REFRESHED 1
`define BIT_INVALID_COMMAND_N 0
// Control fields
`define CTL_PHASE_HI 23
`define CTL_PHASE_LO 16
`define CTL_CUR2_RANGE_SEL 12
`define CTL_EEPROM_STOP 8
`define CTL_CUR1_RANGE_SEL 5
`define CTL_IRQ_OPEN_DRAIN 4
`define CTL_HOST_CLK_OUT_OFF 2
`define CTL_XTAL_OSC_OFF 1
`define CTL_WRITABLE_MASK 24'hFF1136
// Mode control field
`define MODE_CHAN_SEL 0
// AXI responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// ---- meter_regs_props.sv ----
module meter_regs_props (
   // Clock and reset
   input wire CLK_SYS,
   input wire RESETN,
   // Bus handshakes
   input wire S_AXI_AWVALID,
   input wire S_AXI_AWREADY,
   input wire S_AXI_WVALID,
   input wire S_AXI_WREADY,
   input wire [1:0] S_AXI_BRESP,
   input wire S_AXI_BVALID,
   input wire S_AXI_BREADY,
   input wire S_AXI_ARVALID,
   input wire S_AXI_ARREADY,
   input wire [31:0] S_AXI_RDATA,
   input wire S_AXI_RVALID,
   input wire S_AXI_RREADY,
   // Control and interrupt pins
   input wire EEPROM_STOP,
   input wire IRQ_N_OUT,
   input wire IRQ_N_OE
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge CLK_SYS);
   endclocking
   default disable iff (!RESETN);
   ////////////////////////////////////////////////////////////////////////
   // Stop request is a single pulse, and only right after a write
   a_stop_one_cycle: assert property (EEPROM_STOP |=> !EEPROM_STOP)
      else $error("stop pulse longer than one cycle");
   a_stop_from_write: assert property (EEPROM_STOP |->
      S_AXI_BVALID || $past(S_AXI_BVALID) || $past(S_AXI_BVALID, 2))
      else $error("stop pulse without a write");
   // Released open-drain pin never carries a driven low
   a_oe_release_high: assert property (!IRQ_N_OE |-> IRQ_N_OUT)
      else $error("interrupt low while not driven");
   ////////////////////////////////////////////////////////////////////////
   // Answers stand until taken, and come in bounded time
   a_bresp_held: assert property (S_AXI_BVALID && !S_AXI_BREADY |=>
      S_AXI_BVALID && $stable(S_AXI_BRESP))
      else $error("write response dropped early");
   a_rdata_held: assert property (S_AXI_RVALID && !S_AXI_RREADY |=>
      S_AXI_RVALID && $stable(S_AXI_RDATA))
      else $error("read data dropped early");
   a_read_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
      else $error("read answer late");
   a_write_answer: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID
      && S_AXI_WREADY |-> ##[1:4] S_AXI_BVALID)
      else $error("write answer late");
   a_bresp_code: assert property (S_AXI_BVALID |-> S_AXI_BRESP == 2'h0 || S_AXI_BRESP == 2'h2)
      else $error("illegal write response");
   // Registers are 24 bits wide, upper byte reads zero
   a_rdata_upper: assert property (S_AXI_RVALID |-> S_AXI_RDATA[31:24] == 8'h00)
      else $error("upper read byte not zero");
endmodule
bind meter_status_control_regs meter_regs_props i_props (.CLK_SYS(CLK_SYS),
   .RESETN(RESETN), .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
   .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP),
   .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARVALID(S_AXI_ARVALID),
   .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RVALID(S_AXI_RVALID),
   .S_AXI_RREADY(S_AXI_RREADY), .EEPROM_STOP(EEPROM_STOP), .IRQ_N_OUT(IRQ_N_OUT),
   .IRQ_N_OE(IRQ_N_OE));

// ---- meter_status_control_regs.v ----
// Summary of operation
// - Temperature register holds signed Celsius, point bit16.
// - Pulse sources follow channel one or two.
// - Pulse source values are signed fractions.
// - Write-one clears status only when condition gone.
// - Mask bit lets status drive interrupt; resets 0.
// - Low-rate-ready bit 23 sets on update.
// - Sample-ready bit 20 sets on refresh.
// - Instantaneous over-range bits 16,17,21,22.
// - RMS over-range bits 13,14,18,19.
// - Energy over-range bits 12 and 15.
// - Fault bits 11,9; dip bits 10,8.
// - Temperature-updated bit 7 sets on new value.
// - Modulator oscillation bits 6,4,3,5.
// - Low-supply bit 2 with hysteresis hold.
// - Invalid-command bit 0 active low.
// - Control 23:16 sets channel-two phase delay.
// - Range bits 5,12 select 250/50 mV.
// - Writing one to bit 8 stops EEPROM.
// - Control bit 4 selects open-drain interrupt.
// - Control bit 2 disables host clock output.
// - Control bit 1 disables crystal oscillator.
// - Frequency-updated bit 1 sets on update.
// - Channel select lives in mode control register.
`include "meter_regs_defs.vh"
module meter_status_control_regs (
   // Clock and reset
   input wire CLK_SYS,
   input wire RESETN,
   // AXI4-Lite write address
   input wire [31:0] S_AXI_AWADDR,
   input wire S_AXI_AWVALID,
   output reg S_AXI_AWREADY,
   // AXI4-Lite write data
   input wire [31:0] S_AXI_WDATA,
   input wire [3:0] S_AXI_WSTRB,
   input wire S_AXI_WVALID,
   output reg S_AXI_WREADY,
   // AXI4-Lite write response
   output reg [1:0] S_AXI_BRESP,
   output reg S_AXI_BVALID,
   input wire S_AXI_BREADY,
   // AXI4-Lite read address
   input wire [31:0] S_AXI_ARADDR,
   input wire S_AXI_ARVALID,
   output reg S_AXI_ARREADY,
   // AXI4-Lite read data
   output reg [31:0] S_AXI_RDATA,
   output reg [1:0] S_AXI_RRESP,
   output reg S_AXI_RVALID,
   input wire S_AXI_RREADY,
   // Measurement datapath results (same clock)
   input wire [23:0] TEMP_VALUE,
   input wire TEMP_UPDATE,
   input wire [23:0] ACTIVE_AVG1,
   input wire [23:0] APPARENT1,
   input wire [23:0] REACTIVE_AVG1,
   input wire [23:0] ACTIVE_AVG2,
   input wire [23:0] APPARENT2,
   input wire [23:0] REACTIVE_AVG2,
   input wire PULSE_UPDATE,
   // Status events and held conditions from the datapath (same clock)
   input wire [23:0] EVENT_SET,
   input wire [23:0] EVENT_HOLD,
   input wire INVALID_COMMAND,
   // Supply monitor comparator levels (asynchronous pins)
   input wire SUPPLY_BELOW_LOW,
   input wire SUPPLY_ABOVE_HIGH,
   // Control outputs
   output reg [7:0] PHASE_DELAY_FIELD,
   output reg CUR1_RANGE_SEL,
   output reg CUR2_RANGE_SEL,
   output reg EEPROM_STOP,
   output reg HOST_CLK_OUT_OFF,
   output reg XTAL_OSC_OFF,
   output reg PULSE_CHAN_SEL,
   // Interrupt pin as two signals
   output reg IRQ_N_OUT,
   output reg IRQ_N_OE
);

////////////////////////////////////////////////////////////////////////////////
// Functions

// Word index of a byte address; upper bits must be zero to hit
function [8:0] word_index;
   input [31:0] addr;
   begin
      word_index = (addr[31:10] == 22'h000000) ? {1'b1, addr[9:2]} : 9'h000;
   end
endfunction

// Byte-lane merge of a write into a 24-bit register
function [23:0] lane_merge;
   input [23:0] old;
   input [31:0] data;
   input [3:0] strb;
   begin
      lane_merge[7:0] = strb[0] ? data[7:0] : old[7:0];
      lane_merge[15:8] = strb[1] ? data[15:8] : old[15:8];
      lane_merge[23:16] = strb[2] ? data[23:16] : old[23:16];
   end
endfunction

////////////////////////////////////////////////////////////////////////////////
// Storage

reg [23:0] flags_reg; // Status, sticky
reg [23:0] mask_reg; // Interrupt enables
reg [23:0] ctrl_reg; // Control, stop bit not stored
reg [23:0] mode_reg; // Mode control, channel select only used
reg [23:0] temp_reg; // Temperature result
reg [23:0] active_pulse_source_reg; // Active pulse source
reg [23:0] apparent_pulse_source_reg; // Apparent pulse source
reg [23:0] reactive_pulse_source_reg; // Reactive pulse source
reg below_meta_reg; // Synchroniser stage one, read only by stage two
reg below_sync_reg;
reg above_meta_reg;
reg above_sync_reg;
reg low_supply_hold_reg; // Low-supply condition with hysteresis
reg [31:0] awaddr_reg; // Captured write address
reg aw_full_reg;
reg [31:0] wdata_reg; // Captured write data
reg [3:0] wstrb_reg;
reg w_full_reg;

////////////////////////////////////////////////////////////////////////////////
// Write channel: take address and data in any order, then respond

wire wr_go = aw_full_reg && w_full_reg && !S_AXI_BVALID;
wire [8:0] wr_idx = word_index(awaddr_reg);
wire wr_hit = wr_idx[8];
wire [7:0] wr_reg = wr_idx[7:0];
wire wr_flags = wr_go && wr_hit && (wr_reg == `IDX_EVENT_FLAGS);
wire wr_mask = wr_go && wr_hit && (wr_reg == `IDX_EVENT_ENABLE_MASK);
wire wr_ctrl = wr_go && wr_hit && (wr_reg == `IDX_CHIP_CONTROL);
wire wr_mode = wr_go && wr_hit && (wr_reg == `IDX_MODE_CONTROL);
wire wr_ro = wr_go && wr_hit && ((wr_reg == `IDX_TEMPERATURE_RESULT) ||
   (wr_reg == `IDX_ACTIVE_PULSE_SOURCE) || (wr_reg == `IDX_APPARENT_PULSE_SOURCE) ||
   (wr_reg == `IDX_REACTIVE_PULSE_SOURCE));
wire wr_ok = wr_flags || wr_mask || wr_ctrl || wr_mode || wr_ro;
wire [23:0] wr_merged = lane_merge(24'h000000, wdata_reg, wstrb_reg);

// Handshake registers for the write side
always @(posedge CLK_SYS)
begin
   if (!RESETN)
   begin
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY <= 1'b0;
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      awaddr_reg <= 32'h00000000;
      wdata_reg <= 32'h00000000;
      wstrb_reg <= 4'h0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= `RESP_OKAY;
   end
   else
   begin
      // Ready is a one-cycle pulse so each item is taken exactly once
      S_AXI_AWREADY <= S_AXI_AWVALID && !aw_full_reg && !S_AXI_AWREADY;
      S_AXI_WREADY <= S_AXI_WVALID && !w_full_reg && !S_AXI_WREADY;
      if (S_AXI_AWVALID && S_AXI_AWREADY)
      begin
         awaddr_reg <= S_AXI_AWADDR;
         aw_full_reg <= 1'b1;
      end
      if (S_AXI_WVALID && S_AXI_WREADY)
      begin
         wdata_reg <= S_AXI_WDATA;
         wstrb_reg <= S_AXI_WSTRB;
         w_full_reg <= 1'b1;
      end
      if (wr_go)
      begin
         aw_full_reg <= 1'b0;
         w_full_reg <= 1'b0;
         S_AXI_BVALID <= 1'b1;
         S_AXI_BRESP <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (S_AXI_BVALID && S_AXI_BREADY)
         S_AXI_BVALID <= 1'b0;
   end
end

////////////////////////////////////////////////////////////////////////////////
// Read channel

wire [8:0] rd_idx = word_index(S_AXI_ARADDR);
reg [23:0] rd_word;
reg rd_ok;

// Read mux; unmapped addresses answer zero with an error
always @*
begin
   rd_ok = rd_idx[8];
   rd_word = 24'h000000;
   case (rd_idx[7:0])
      `IDX_EVENT_FLAGS: rd_word = flags_reg;
      `IDX_EVENT_ENABLE_MASK: rd_word = mask_reg;
      `IDX_TEMPERATURE_RESULT: rd_word = temp_reg;
      `IDX_CHIP_CONTROL: rd_word = ctrl_reg;
      `IDX_MODE_CONTROL: rd_word = mode_reg;
      `IDX_ACTIVE_PULSE_SOURCE: rd_word = active_pulse_source_reg;
      `IDX_APPARENT_PULSE_SOURCE: rd_word = apparent_pulse_source_reg;
      `IDX_REACTIVE_PULSE_SOURCE: rd_word = reactive_pulse_source_reg;
      default: rd_ok = 1'b0;
   endcase
end

// Read handshake; data sampled when the address is taken
always @(posedge CLK_SYS)
begin
   if (!RESETN)
   begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h00000000;
      S_AXI_RRESP <= `RESP_OKAY;
   end
   else
   begin
      S_AXI_ARREADY <= S_AXI_ARVALID && !S_AXI_RVALID && !S_AXI_ARREADY;
      if (S_AXI_ARVALID && S_AXI_ARREADY)
      begin
         S_AXI_RVALID <= 1'b1;
         S_AXI_RDATA <= {8'h00, rd_word};
         S_AXI_RRESP <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (S_AXI_RVALID && S_AXI_RREADY)
         S_AXI_RVALID <= 1'b0;
   end
end

////////////////////////////////////////////////////////////////////////////////
// Supply monitor synchronisers and hysteresis

// Two flops per pin before any logic looks at the levels
always @(posedge CLK_SYS)
begin
   if (!RESETN)
   begin
      below_meta_reg <= 1'b0;
      below_sync_reg <= 1'b0;
      above_meta_reg <= 1'b0;
      above_sync_reg <= 1'b0;
      low_supply_hold_reg <= 1'b0;
   end
   else
   begin
      below_meta_reg <= SUPPLY_BELOW_LOW;
      below_sync_reg <= below_meta_reg;
      above_meta_reg <= SUPPLY_ABOVE_HIGH;
      above_sync_reg <= above_meta_reg;
      // Held from dropping below low until rising above high
      if (below_sync_reg)
         low_supply_hold_reg <= 1'b1;
      else if (above_sync_reg)
         low_supply_hold_reg <= 1'b0;
   end
end

////////////////////////////////////////////////////////////////////////////////
// Status set, clear and hold

reg [23:0] set_vec; // Events that set a bit this cycle
reg [23:0] hold_vec; // Conditions still present, block a clear
reg [23:0] flags_next;

// Set beats clear; a write-one clear is refused while the cause persists
always @*
begin
   set_vec = EVENT_SET;
   set_vec[`BIT_TEMP_REFRESHED] = EVENT_SET[`BIT_TEMP_REFRESHED] | TEMP_UPDATE;
   set_vec[`BIT_LOW_SUPPLY_FLAG] = low_supply_hold_reg;
   set_vec[`BIT_INVALID_COMMAND_N] = 1'b0;
   hold_vec = EVENT_HOLD;
   hold_vec[`BIT_LOW_SUPPLY_FLAG] = low_supply_hold_reg;
   hold_vec[`BIT_INVALID_COMMAND_N] = 1'b0;
   flags_next = flags_reg;
   if (wr_flags)
      flags_next = flags_reg & ~(wr_merged & ~hold_vec);
   flags_next = flags_next | set_vec;
   // Active-low bit: a bad command drops it, a write of one restores it
   if (INVALID_COMMAND)
      flags_next[`BIT_INVALID_COMMAND_N] = 1'b0;
   else if (wr_flags && wr_merged[`BIT_INVALID_COMMAND_N])
      flags_next[`BIT_INVALID_COMMAND_N] = 1'b1;
   else
      flags_next[`BIT_INVALID_COMMAND_N] = flags_reg[`BIT_INVALID_COMMAND_N];
end

////////////////////////////////////////////////////////////////////////////////
// Register updates

// Writable and datapath-loaded registers
always @(posedge CLK_SYS)
begin
   if (!RESETN)
   begin
      flags_reg <= `RST_EVENT_FLAGS;
      mask_reg <= `RST_EVENT_ENABLE_MASK;
      ctrl_reg <= `RST_CHIP_CONTROL;
      mode_reg <= `RST_MODE_CONTROL;
      temp_reg <= 24'h000000;
      active_pulse_source_reg <= 24'h000000;
      apparent_pulse_source_reg <= 24'h000000;
      reactive_pulse_source_reg <= 24'h000000;
      EEPROM_STOP <= 1'b0;
   end
   else
   begin
      flags_reg <= flags_next;
      if (wr_mask)
         mask_reg <= lane_merge(mask_reg, wdata_reg, wstrb_reg);
      // Stop is a command bit: it pulses and never reads back as one
      if (wr_ctrl)
         ctrl_reg <= lane_merge(ctrl_reg, wdata_reg, wstrb_reg) & `CTL_WRITABLE_MASK &
            ~(24'h000001 << `CTL_EEPROM_STOP);
      EEPROM_STOP <= wr_ctrl && wstrb_reg[1] && wdata_reg[`CTL_EEPROM_STOP];
      if (wr_mode)
         mode_reg <= lane_merge(mode_reg, wdata_reg, wstrb_reg) & 24'h000001;
      if (TEMP_UPDATE)
         temp_reg <= TEMP_VALUE;
      // Pulse sources copy the selected channel's averages
      if (PULSE_UPDATE)
      begin
         active_pulse_source_reg <= mode_reg[`MODE_CHAN_SEL] ? ACTIVE_AVG2 : ACTIVE_AVG1;
         apparent_pulse_source_reg <= mode_reg[`MODE_CHAN_SEL] ? APPARENT2 : APPARENT1;
         reactive_pulse_source_reg <= mode_reg[`MODE_CHAN_SEL] ? REACTIVE_AVG2 : REACTIVE_AVG1;
      end
   end
end

////////////////////////////////////////////////////////////////////////////////
// Control outputs and interrupt pin

// All outputs registered; interrupt follows flags one cycle later
always @(posedge CLK_SYS)
begin
   if (!RESETN)
   begin
      PHASE_DELAY_FIELD <= 8'h00;
      CUR1_RANGE_SEL <= 1'b0;
      CUR2_RANGE_SEL <= 1'b0;
      HOST_CLK_OUT_OFF <= 1'b0;
      XTAL_OSC_OFF <= 1'b0;
      PULSE_CHAN_SEL <= 1'b0;
      IRQ_N_OUT <= 1'b1;
      IRQ_N_OE <= 1'b1;
   end
   else
   begin
      PHASE_DELAY_FIELD <= ctrl_reg[`CTL_PHASE_HI:`CTL_PHASE_LO];
      CUR1_RANGE_SEL <= ctrl_reg[`CTL_CUR1_RANGE_SEL];
      CUR2_RANGE_SEL <= ctrl_reg[`CTL_CUR2_RANGE_SEL];
      HOST_CLK_OUT_OFF <= ctrl_reg[`CTL_HOST_CLK_OUT_OFF];
      XTAL_OSC_OFF <= ctrl_reg[`CTL_XTAL_OSC_OFF];
      PULSE_CHAN_SEL <= mode_reg[`MODE_CHAN_SEL];
      IRQ_N_OUT <= ~|(flags_reg & mask_reg);
      // Open drain drives only the low level; push-pull always drives
      if (ctrl_reg[`CTL_IRQ_OPEN_DRAIN])
         IRQ_N_OE <= |(flags_reg & mask_reg);
      else
         IRQ_N_OE <= 1'b1;
   end
end

endmodule

// ---- meter_status_control_regs_tb_top.sv ----
`include "meter_regs_defs.vh"
module meter_status_control_regs_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   // Clock, reset and datapath stimulus
   logic CLK_SYS = 0;
   logic RESETN = 0;
   logic [23:0] temp_v = 0, a1 = 0, s1 = 0, q1 = 0, a2 = 0, s2 = 0, q2 = 0;
   logic [23:0] ev_set = 0, ev_hold = 0;
   logic temp_up = 0, pulse_up = 0, inv_cmd = 0, below = 0, above = 0;
   // Bus wires and design outputs
   wire [31:0] awaddr, wdata, araddr, rdata;
   wire [3:0] wstrb;
   wire [1:0] bresp, rresp;
   wire awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
   wire [7:0] phase;
   wire cur1_rng, cur2_rng, stop, clk_off, osc_off, chan_sel, irq_n, irq_oe;
   int n_fail = 0, checks_done = 0, stops = 0;
   meter_status_control_regs i_meter_status_control_regs (.CLK_SYS(CLK_SYS), .RESETN(RESETN),
      .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
      .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
      .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
      .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
      .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
      .TEMP_VALUE(temp_v), .TEMP_UPDATE(temp_up), .ACTIVE_AVG1(a1), .APPARENT1(s1),
      .REACTIVE_AVG1(q1), .ACTIVE_AVG2(a2), .APPARENT2(s2), .REACTIVE_AVG2(q2),
      .PULSE_UPDATE(pulse_up), .EVENT_SET(ev_set), .EVENT_HOLD(ev_hold),
      .INVALID_COMMAND(inv_cmd), .SUPPLY_BELOW_LOW(below), .SUPPLY_ABOVE_HIGH(above),
      .PHASE_DELAY_FIELD(phase), .CUR1_RANGE_SEL(cur1_rng), .CUR2_RANGE_SEL(cur2_rng),
      .EEPROM_STOP(stop), .HOST_CLK_OUT_OFF(clk_off), .XTAL_OSC_OFF(osc_off),
      .PULSE_CHAN_SEL(chan_sel), .IRQ_N_OUT(irq_n), .IRQ_N_OE(irq_oe));
   host_axi_model host (.CLK_SYS(CLK_SYS), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
   ////////////////////////////////////////////////////////////////////////
   initial forever #2 CLK_SYS = ~CLK_SYS;
   // Count stop pulses so a missing or extra one shows up
   always @(posedge CLK_SYS) if (stop === 1'b1) stops++;
   task wrap_up;
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task chk(input string what, input [31:0] exp_v, input [31:0] got);
      checks_done++;
      if (exp_v !== got)
      begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", what, exp_v, got);
      end
   endtask
   // Read and compare data and response code
   task rchk(input [7:0] idx, input [23:0] exp_v, input [1:0] exp_r = `RESP_OKAY);
      logic [31:0] d;
      logic [1:0] r;
      host.rd(idx, d, r);
      chk("read data", {8'h00, exp_v}, d);
      chk("read response", {30'h0, exp_r}, {30'h0, r});
   endtask
   task wr(input [7:0] idx, input [23:0] v, input [1:0] exp_r = `RESP_OKAY);
      logic [1:0] r;
      host.wr(idx, {8'h00, v}, 4'h7, r);
      chk("write response", {30'h0, exp_r}, {30'h0, r});
   endtask
   task pulse(input [23:0] b, input logic tu, input logic pu, input logic ic);
      @(posedge CLK_SYS);
      {ev_set, temp_up, pulse_up, inv_cmd} <= {b, tu, pu, ic};
      @(posedge CLK_SYS);
      {ev_set, temp_up, pulse_up, inv_cmd} <= 0;
   endtask
   ////////////////////////////////////////////////////////////////////////
   task t_ctrl;
      logic [1:0] r;
      rchk(`IDX_EVENT_FLAGS, 24'h000001);
      rchk(`IDX_EVENT_ENABLE_MASK, 24'h000000);
      wr(`IDX_CHIP_CONTROL, 24'hFFFFFF);
      rchk(`IDX_CHIP_CONTROL, 24'hFF1036);
      chk("control pins", 32'h00000FFF, {phase, cur1_rng, cur2_rng, clk_off, osc_off});
      chk("stop pulses", 1, stops);
      // Upper lanes only: low byte must survive, a zero stop bit does nothing
      host.wr(`IDX_CHIP_CONTROL, 32'h00000000, 4'h6, r);
      chk("write response", 0, {30'h0, r});
      rchk(`IDX_CHIP_CONTROL, 24'h000036);
      wr(`IDX_CHIP_CONTROL, 24'h000000);
      repeat (2) @(posedge CLK_SYS);
      chk("control pins", 0, {phase, cur1_rng, cur2_rng, clk_off, osc_off});
      chk("stop pulses", 1, stops);
   endtask
   // Each event bit sets alone and clears by write-one
   task t_events;
      static int bits[22] = '{23, 20, 17, 16, 21, 22, 14, 13, 19, 18, 12, 15, 11, 9, 10, 8, 7, 6,
         4, 3, 5, 1};
      foreach (bits[i])
      begin
         pulse(24'h000001 << bits[i], 0, 0, 0);
         rchk(`IDX_EVENT_FLAGS, (24'h000001 << bits[i]) | 24'h000001);
         wr(`IDX_EVENT_FLAGS, 24'h000001 << bits[i]);
         rchk(`IDX_EVENT_FLAGS, 24'h000001);
      end
   endtask
   task t_hold;
      ev_hold <= 24'h000800;
      pulse(24'h000880, 0, 0, 0);
      wr(`IDX_EVENT_FLAGS, 24'h000000);
      rchk(`IDX_EVENT_FLAGS, 24'h000881);
      wr(`IDX_EVENT_FLAGS, 24'h000880);
      rchk(`IDX_EVENT_FLAGS, 24'h000801);
      ev_hold <= 24'h000000;
      wr(`IDX_EVENT_FLAGS, 24'h000800);
      rchk(`IDX_EVENT_FLAGS, 24'h000001);
   endtask
   task t_irq;
      wr(`IDX_EVENT_ENABLE_MASK, 24'h000080);
      temp_v <= 24'h9C8000;
      pulse(0, 1, 0, 0);
      rchk(`IDX_TEMPERATURE_RESULT, 24'h9C8000);
      rchk(`IDX_EVENT_FLAGS, 24'h000081);
      chk("interrupt pin", 32'h1, {irq_n, irq_oe});
      wr(`IDX_CHIP_CONTROL, 24'h000010);
      wr(`IDX_TEMPERATURE_RESULT, 24'h123456);
      rchk(`IDX_TEMPERATURE_RESULT, 24'h9C8000);
      chk("interrupt pin", 32'h1, {irq_n, irq_oe});
      wr(`IDX_EVENT_FLAGS, 24'h000080);
      repeat (3) @(posedge CLK_SYS);
      chk("interrupt pin", 32'h2, {irq_n, irq_oe});
      wr(`IDX_EVENT_ENABLE_MASK, 24'h000000);
      pulse(24'h000080, 0, 0, 0);
      wr(`IDX_CHIP_CONTROL, 24'h000000);
      repeat (3) @(posedge CLK_SYS);
      chk("interrupt pin", 32'h3, {irq_n, irq_oe});
      wr(`IDX_EVENT_FLAGS, 24'h000080);
   endtask
   task t_pulse;
      {a1, s1, q1, a2, s2, q2} <= {72'h8000007FFFFF123456, 72'hFFFFFF000001654321};
      pulse(0, 0, 1, 0);
      rchk(`IDX_ACTIVE_PULSE_SOURCE, 24'h800000);
      rchk(`IDX_APPARENT_PULSE_SOURCE, 24'h7FFFFF);
      rchk(`IDX_REACTIVE_PULSE_SOURCE, 24'h123456);
      wr(`IDX_MODE_CONTROL, 24'h000001);
      pulse(0, 0, 1, 0);
      chk("channel select", 1, chan_sel);
      rchk(`IDX_ACTIVE_PULSE_SOURCE, 24'hFFFFFF);
      rchk(`IDX_APPARENT_PULSE_SOURCE, 24'h000001);
      rchk(`IDX_REACTIVE_PULSE_SOURCE, 24'h654321);
   endtask
   // Invalid command, supply hysteresis, unmapped address
   task t_misc;
      pulse(0, 0, 0, 1);
      rchk(`IDX_EVENT_FLAGS, 24'h000000);
      wr(`IDX_EVENT_FLAGS, 24'h000001);
      below <= 1'b1;
      repeat (4) @(posedge CLK_SYS);
      below <= 1'b0;
      wr(`IDX_EVENT_FLAGS, 24'h000004);
      rchk(`IDX_EVENT_FLAGS, 24'h000005);
      above <= 1'b1;
      repeat (4) @(posedge CLK_SYS);
      wr(`IDX_EVENT_FLAGS, 24'h000004);
      rchk(`IDX_EVENT_FLAGS, 24'h000001);
      rchk(8'h05, 24'h000000, `RESP_SLVERR);
      wr(8'h05, 24'hFFFFFF, `RESP_SLVERR);
   endtask
   // Mid-run reset brings registers and pins back to their defaults
   task t_reset;
      wr(`IDX_CHIP_CONTROL, 24'hFF1036);
      wr(`IDX_EVENT_ENABLE_MASK, 24'h000001);
      @(posedge CLK_SYS);
      RESETN <= 1'b0;
      repeat (8) @(posedge CLK_SYS);
      RESETN <= 1'b1;
      chk("pins after reset", 32'h3, {phase, cur1_rng, cur2_rng, clk_off, osc_off, irq_n, irq_oe});
      rchk(`IDX_CHIP_CONTROL, 24'h000000);
      rchk(`IDX_EVENT_ENABLE_MASK, 24'h000000);
      rchk(`IDX_EVENT_FLAGS, 24'h000001);
   endtask
   // Run is far shorter than this; a hang lands here
   initial
   begin
      #100000;
      n_fail++;
      wrap_up;
   end
   initial
   begin
      repeat (8) @(posedge CLK_SYS);
      RESETN <= 1'b1;
      t_ctrl;
      t_events;
      t_hold;
      t_irq;
      t_pulse;
      t_misc;
      t_reset;
      wrap_up;
   end
endmodule
